// ---- hw/ccp_pkg.sv ----
// Shared constants, codes and state types of the dual capture/compare block
package ccp_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned VALUE_W    = 16;
  localparam int unsigned UNITS      = 2;

  // Register offsets (word index on the plain register port)
  localparam logic [3:0] OFS_VALUE_LOW   = 4'h0;
  localparam logic [3:0] OFS_VALUE_HIGH  = 4'h1;
  localparam logic [3:0] OFS_CONTROL     = 4'h2;
  localparam logic [3:0] UNIT_STRIDE     = 4'h3;
  localparam logic [3:0] ADDR_T3_CONTROL = 4'h6;
  localparam logic [3:0] ADDR_FLAGS      = 4'h7;
  localparam logic [3:0] ADDR_ENABLES    = 4'h8;
  localparam logic [3:0] ADDR_PRIORITIES = 4'h9;

  // Field positions
  localparam int unsigned CTRL_W         = 6;
  localparam int unsigned MODE_LSB       = 0;
  localparam int unsigned MODE_W         = 4;
  localparam int unsigned UNIT_BIT_LSB   = 1;
  localparam int unsigned ASSIGN_LOW_BIT = 3;
  localparam int unsigned ASSIGN_HI_BIT  = 6;

  // Reset values
  localparam logic [7:0]  T3_CONTROL_RST = 8'h00;
  localparam logic [5:0]  CONTROL_RST    = 6'h00;
  localparam logic [15:0] VALUE_RST      = 16'h0000;

  // Mode select codes
  localparam logic [3:0] MODE_OFF        = 4'h0;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET    = 4'h8;
  localparam logic [3:0] MODE_CMP_CLEAR  = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT   = 4'hA;
  localparam logic [3:0] MODE_CMP_TRIG   = 4'hB;
  localparam logic [1:0] PREFIX_CAPTURE  = 2'h1;
  localparam logic [1:0] PREFIX_PWM      = 2'h3;

  // Capture prescaler
  localparam int unsigned PRESC_W        = 4;
  localparam logic [3:0]  PRESC_LAST4    = 4'h3;
  localparam logic [3:0]  PRESC_LAST16   = 4'hF;

  typedef struct packed {
    logic                 sync1;
    logic                 sync2;
    logic                 prev;
    logic [PRESC_W-1:0]   presc;
    logic                 capture;
  } unit_state_t;

  typedef struct packed {
    logic [1:0][15:0] value;
    logic [1:0][5:0]  control;
    logic [7:0]       t3_control;
    logic [1:0]       flag;
    logic [1:0]       enable;
    logic [1:0]       priority_bit;
    logic [1:0]       cmp_latch;
    logic [1:0]       match_prev;
    logic [1:0]       timer_reset;
    logic             adc_start;
    logic [7:0]       rdata;
  } top_state_t;

endpackage : ccp_pkg

// ---- hw/ccp_unit_if.sv ----
// Link between the register block and one capture edge engine
interface ccp_unit_if;
  logic       pin_async;
  logic       port_latch;
  logic       dir_input;
  logic [3:0] mode;
  logic       capture_stb;

  modport engine (
    input  pin_async,
    input  port_latch,
    input  dir_input,
    input  mode,
    output capture_stb
  );

  modport ctrl (
    output pin_async,
    output port_latch,
    output dir_input,
    output mode,
    input  capture_stb
  );
endinterface : ccp_unit_if

// ---- hw/ccp_edge_engine.sv ----
// Pin synchroniser, edge detector and capture prescaler of one unit
module ccp_edge_engine
  import ccp_pkg::*;
(
  // Clock and reset
  input  wire logic   ref_clk_i,
  input  wire logic   rstn_i,
  // Unit link
  ccp_unit_if.engine  link
);

  unit_state_t st_r;
  unit_state_t st_nxt;

  always_comb begin
    logic level;
    logic rise;
    logic fall;
    level  = 1'b0;
    rise   = 1'b0;
    fall   = 1'b0;
    st_nxt = st_r;
    st_nxt.sync1 = link.pin_async;
    st_nxt.sync2 = st_r.sync1;
    // With the pin turned to output, a port write reaches the detector
    level = link.dir_input ? st_r.sync2 : link.port_latch;
    rise  = level & ~st_r.prev;
    fall  = ~level & st_r.prev;
    st_nxt.prev    = level;
    st_nxt.capture = 1'b0;
    if (link.mode[3:2] != PREFIX_CAPTURE) begin
      st_nxt.presc = '0;
    end else begin
      // Prescaler keeps counting across a direct prescaler switch
      case (link.mode)
        MODE_CAP_FALL: begin
          st_nxt.capture = fall;
        end
        MODE_CAP_RISE: begin
          st_nxt.capture = rise;
        end
        MODE_CAP_RISE4: begin
          if (rise) begin
            st_nxt.presc   = st_r.presc + 4'h1;
            st_nxt.capture = (st_r.presc[1:0] == PRESC_LAST4[1:0]);
          end
        end
        default: begin
          if (rise) begin
            st_nxt.presc   = st_r.presc + 4'h1;
            st_nxt.capture = (st_r.presc == PRESC_LAST16);
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.capture_stb = st_r.capture;

endmodule // ccp_edge_engine

// ---- hw/dual_capture_compare_unit.sv ----
// Two capture/compare units with register port, timer resets and converter trigger
//
// Behaviour
// - Capture copies assigned 16-bit timer into value
// - Four capture events: fall, rise, 4th, 16th
// - Capture sets flag; only software clears it
// - New capture overwrites unread value silently
// - Output-direction port write can trigger capture
// - Mode change may raise false capture flag
// - Prescaler cleared when off or not capturing
// - Prescaler switch keeps count, may flag
// - Compare match: pin action and flag together
// - Control write zero forces compare latch low
// - Code 1010: flag only, pin untouched
// - Code 1011: match resets assigned timer
// - Second unit trigger starts enabled converter
// - First unit trigger never starts converter
// - Each unit picks first or third timer
// - Shared timer reset affects other unit
// - Both PWM units share one timer
// - Capture codes 0100, 0101, 0110, 0111
// - Compare codes 0010 toggle, 1000, 1001
// - 0000 off and reset; 0001/0011 reserved; 11xx PWM
//
// The address map and the address-and-strobe port were left to the implementer.
module dual_capture_compare_unit
  import ccp_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rstn_i,
  // Register port
  input  wire logic [ADDR_W-1:0]   reg_addr_i,
  input  wire logic [DATA_W-1:0]   reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic      [DATA_W-1:0]   reg_rdata_o,
  // Time bases
  input  wire logic [VALUE_W-1:0]  first_timer_i,
  input  wire logic [VALUE_W-1:0]  third_timer_i,
  output logic                     first_timer_reset_o,
  output logic                     third_timer_reset_o,
  // Converter
  input  wire logic                adc_enabled_i,
  output logic                     adc_start_o,
  // Unit pins, index 0 is the first unit
  input  wire logic [UNITS-1:0]    pin_i,
  input  wire logic [UNITS-1:0]    port_latch_i,
  input  wire logic [UNITS-1:0]    pin_direction_bit_i,
  output logic      [UNITS-1:0]    pin_o,
  output logic      [UNITS-1:0]    pin_oe_n_o,
  // Status
  output logic      [UNITS-1:0]    unit_irq_o,
  output logic      [UNITS-1:0]    pwm_mode_o,
  output logic                     pwm_timer_shared_o
);

  top_state_t st_r;
  top_state_t st_nxt;

  logic [UNITS-1:0] capture_stb;

  // Address of a register within a unit's register group
  function automatic logic [3:0] unit_addr(input int unsigned unit, input logic [3:0] ofs);
    unit_addr = 4'(unit * UNIT_STRIDE) + ofs;
  endfunction

  // 1 selects the third timer for the given unit
  function automatic logic uses_third(input logic [7:0] t3c, input int unsigned unit);
    logic hi;
    logic lo;
    hi = t3c[ASSIGN_HI_BIT];
    lo = t3c[ASSIGN_LOW_BIT];
    if (hi) begin
      uses_third = 1'b1;
    end else if (lo) begin
      uses_third = (unit != 0);
    end else begin
      uses_third = 1'b0;
    end
  endfunction

  function automatic logic mode_capture(input logic [5:0] ctrl);
    mode_capture = (ctrl[3:2] == PREFIX_CAPTURE);
  endfunction

  // Compare codes 0010 and 10xx; 0001 and 0011 stay idle
  function automatic logic mode_compare(input logic [5:0] ctrl);
    logic [3:0] m;
    m = ctrl[MODE_LSB +: MODE_W];
    mode_compare = (m == MODE_CMP_TOGGLE) || (m[3:2] == 2'h2);
  endfunction

  // Compare latch level at a control write
  function automatic logic start_level(input logic [3:0] m, input logic cur);
    if (m == MODE_OFF) begin
      start_level = 1'b0;
    end else if (m == MODE_CMP_SET) begin
      start_level = 1'b0;
    end else if (m == MODE_CMP_CLEAR) begin
      start_level = 1'b1;
    end else begin
      start_level = cur;
    end
  endfunction

  // Pin is driven by the compare latch only in the pin-changing compare modes
  function automatic logic latch_drives(input logic [5:0] ctrl);
    logic [3:0] m;
    m = ctrl[MODE_LSB +: MODE_W];
    latch_drives = (m == MODE_CMP_TOGGLE) || (m == MODE_CMP_SET) || (m == MODE_CMP_CLEAR);
  endfunction

  // Edge engines
  for (genvar g = 0; g < UNITS; g++) begin : g_unit
    ccp_unit_if link ();

    assign link.pin_async  = pin_i[g];
    assign link.port_latch = port_latch_i[g];
    assign link.dir_input  = pin_direction_bit_i[g];
    assign link.mode       = st_r.control[g][MODE_LSB +: MODE_W];
    assign capture_stb[g]  = link.capture_stb;

    ccp_edge_engine u_engine (
      .ref_clk_i (ref_clk_i),
      .rstn_i    (rstn_i),
      .link      (link)
    );
  end

  always_comb begin
    logic [UNITS-1:0][VALUE_W-1:0] tval;
    logic [UNITS-1:0]              sel3;
    logic                          eq;
    logic [3:0]                    m;
    tval   = '0;
    sel3   = '0;
    eq     = 1'b0;
    m      = 4'h0;
    st_nxt = st_r;
    st_nxt.rdata       = '0;
    st_nxt.timer_reset = '0;
    st_nxt.adc_start   = 1'b0;

    for (int unsigned u = 0; u < UNITS; u++) begin
      sel3[u] = uses_third(st_r.t3_control, u);
      tval[u] = sel3[u] ? third_timer_i : first_timer_i;
    end

    // Software writes first; hardware events below take precedence
    if (reg_wr_i) begin
      for (int unsigned u = 0; u < UNITS; u++) begin
        if (reg_addr_i == unit_addr(u, OFS_VALUE_LOW)) begin
          st_nxt.value[u][7:0] = reg_wdata_i;
        end else if (reg_addr_i == unit_addr(u, OFS_VALUE_HIGH)) begin
          st_nxt.value[u][15:8] = reg_wdata_i;
        end else if (reg_addr_i == unit_addr(u, OFS_CONTROL)) begin
          st_nxt.control[u]   = reg_wdata_i[CTRL_W-1:0];
          st_nxt.cmp_latch[u] = start_level(reg_wdata_i[MODE_LSB +: MODE_W],
                                            st_r.cmp_latch[u]);
        end
      end
      if (reg_addr_i == ADDR_T3_CONTROL) begin
        st_nxt.t3_control = reg_wdata_i;
      end else if (reg_addr_i == ADDR_FLAGS) begin
        st_nxt.flag = reg_wdata_i[UNIT_BIT_LSB +: UNITS];
      end else if (reg_addr_i == ADDR_ENABLES) begin
        st_nxt.enable = reg_wdata_i[UNIT_BIT_LSB +: UNITS];
      end else if (reg_addr_i == ADDR_PRIORITIES) begin
        st_nxt.priority_bit = reg_wdata_i[UNIT_BIT_LSB +: UNITS];
      end
    end

    for (int unsigned u = 0; u < UNITS; u++) begin
      m  = st_r.control[u][MODE_LSB +: MODE_W];
      eq = mode_compare(st_r.control[u]) && (st_r.value[u] == tval[u]);
      st_nxt.match_prev[u] = eq;

      // Capture overwrites unread data; flag set beats a same-cycle clear
      if (capture_stb[u] && mode_capture(st_r.control[u])) begin
        st_nxt.value[u] = tval[u];
        st_nxt.flag[u]  = 1'b1;
      end

      // Act once per match, not for every cycle the timer rests on it
      if (eq && !st_r.match_prev[u]) begin
        st_nxt.flag[u] = 1'b1;
        case (m)
          MODE_CMP_TOGGLE: begin
            st_nxt.cmp_latch[u] = ~st_r.cmp_latch[u];
          end
          MODE_CMP_SET: begin
            st_nxt.cmp_latch[u] = 1'b1;
          end
          MODE_CMP_CLEAR: begin
            st_nxt.cmp_latch[u] = 1'b0;
          end
          MODE_CMP_TRIG: begin
            // Shared time base reset hits both units alike
            st_nxt.timer_reset[sel3[u]] = 1'b1;
            if ((u != 0) && adc_enabled_i) begin
              st_nxt.adc_start = 1'b1;
            end
          end
          default: begin
            st_nxt.cmp_latch[u] = st_r.cmp_latch[u];
          end
        endcase
      end
    end

    // Read data live for exactly one cycle; unmapped reads give zero
    if (reg_rd_i) begin
      for (int unsigned u = 0; u < UNITS; u++) begin
        if (reg_addr_i == unit_addr(u, OFS_VALUE_LOW)) begin
          st_nxt.rdata = st_r.value[u][7:0];
        end else if (reg_addr_i == unit_addr(u, OFS_VALUE_HIGH)) begin
          st_nxt.rdata = st_r.value[u][15:8];
        end else if (reg_addr_i == unit_addr(u, OFS_CONTROL)) begin
          st_nxt.rdata = {2'h0, st_r.control[u]};
        end
      end
      if (reg_addr_i == ADDR_T3_CONTROL) begin
        st_nxt.rdata = st_r.t3_control;
      end else if (reg_addr_i == ADDR_FLAGS) begin
        st_nxt.rdata = 8'({st_r.flag, 1'b0});
      end else if (reg_addr_i == ADDR_ENABLES) begin
        st_nxt.rdata = 8'({st_r.enable, 1'b0});
      end else if (reg_addr_i == ADDR_PRIORITIES) begin
        st_nxt.rdata = 8'({st_r.priority_bit, 1'b0});
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r              <= '0;
      st_r.value        <= {UNITS{VALUE_RST}};
      st_r.control      <= {UNITS{CONTROL_RST}};
      st_r.t3_control   <= T3_CONTROL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign reg_rdata_o         = st_r.rdata;
  assign first_timer_reset_o = st_r.timer_reset[0];
  assign third_timer_reset_o = st_r.timer_reset[1];
  assign adc_start_o         = st_r.adc_start;

  always_comb begin
    for (int unsigned u = 0; u < UNITS; u++) begin
      // Soft-interrupt and trigger modes leave the port latch on the pin
      pin_o[u]      = latch_drives(st_r.control[u]) ? st_r.cmp_latch[u] : port_latch_i[u];
      pin_oe_n_o[u] = pin_direction_bit_i[u];
      unit_irq_o[u] = st_r.flag[u] & st_r.enable[u];
      pwm_mode_o[u] = (st_r.control[u][3:2] == PREFIX_PWM);
    end
  end

  // PWM units have no private period timer; both run from the one pwm timer
  assign pwm_timer_shared_o = &pwm_mode_o;

endmodule // dual_capture_compare_unit

// ---- tb/ccp_assertions.sv ----
// Port-level checks for the dual capture/compare block
module ccp_assertions
  import ccp_pkg::*;
(
  // Clock and reset
  input wire logic              ref_clk_i,
  input wire logic              rstn_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic              reg_wr_i,
  // Watched outputs and converter level
  input wire logic [UNITS-1:0]  pin_o,
  input wire logic              adc_enabled_i,
  input wire logic              adc_start_o,
  input wire logic              first_timer_reset_o,
  input wire logic              third_timer_reset_o,
  input wire logic [UNITS-1:0]  unit_irq_o,
  input wire logic [UNITS-1:0]  pwm_mode_o,
  input wire logic              pwm_timer_shared_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_flag_hold0;
    $fell(unit_irq_o[0]) |-> $past(reg_wr_i);
  endproperty
  a_flag_hold0: assert property (p_flag_hold0)
    else $error("unit 1 request dropped without a write");
  property p_flag_hold1;
    $fell(unit_irq_o[1]) |-> $past(reg_wr_i);
  endproperty
  a_flag_hold1: assert property (p_flag_hold1)
    else $error("unit 2 request dropped without a write");
  property p_adc_en;
    adc_start_o |-> $past(adc_enabled_i);
  endproperty
  a_adc_en: assert property (p_adc_en)
    else $error("conversion started while converter off");
  property p_adc_rst;
    adc_start_o |-> (first_timer_reset_o || third_timer_reset_o);
  endproperty
  a_adc_rst: assert property (p_adc_rst)
    else $error("conversion start without timer reset");
  property p_adc_pulse;
    adc_start_o |=> !adc_start_o;
  endproperty
  a_adc_pulse: assert property (p_adc_pulse)
    else $error("conversion start longer than one cycle");
  property p_rst1_pulse;
    first_timer_reset_o |=> !first_timer_reset_o;
  endproperty
  a_rst1_pulse: assert property (p_rst1_pulse)
    else $error("first timer reset longer than one cycle");
  property p_rst3_pulse;
    third_timer_reset_o |=> !third_timer_reset_o;
  endproperty
  a_rst3_pulse: assert property (p_rst3_pulse)
    else $error("third timer reset longer than one cycle");
  // Mode output must follow the code written to the first unit's control
  property p_pwm_mode;
    reg_wr_i && reg_addr_i == OFS_CONTROL
      |=> pwm_mode_o[0] == ($past(reg_wdata_i[3:2]) == PREFIX_PWM);
  endproperty
  a_pwm_mode: assert property (p_pwm_mode)
    else $error("pwm mode output does not follow control write");
  property p_start_low;
    reg_wr_i && reg_addr_i == OFS_CONTROL && reg_wdata_i[3:0] == MODE_CMP_SET |=> !pin_o[0];
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("set-on-match mode did not start low");
  property p_start_high;
    reg_wr_i && reg_addr_i == OFS_CONTROL && reg_wdata_i[3:0] == MODE_CMP_CLEAR |=> pin_o[0];
  endproperty
  a_start_high: assert property (p_start_high)
    else $error("clear-on-match mode did not start high");

  c_adc: cover property (adc_start_o);
  c_rst3: cover property (third_timer_reset_o);
  c_irq: cover property ($rose(unit_irq_o[1]));
  c_pwm: cover property (pwm_timer_shared_o);
endmodule // ccp_assertions

// ---- tb/pin_source.sv ----
// External signal source driving the unit pins
module pin_source (
  // Requested levels
  input  wire logic [1:0] want_i,
  // Pad levels
  output logic      [1:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin_o = 2'b00;
  // Edges land at random points 7 to 27 ns after the clock edge that changed the request
  always @(want_i) pin_o <= #(7 + $urandom_range(20)) want_i;
endmodule // pin_source

// ---- tb/tb.sv ----
// Self-checking bench for the dual capture/compare block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ccp_pkg::*;
  logic        ref_clk_i, rstn_i, reg_wr_i, reg_rd_i, adc_enabled_i, adc_start_o, run, rd_d;
  logic [3:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o, v;
  logic [15:0] first_timer_i, third_timer_i, t;
  logic        first_timer_reset_o, third_timer_reset_o, pwm_timer_shared_o;
  logic [1:0]  pin_i, port_latch_i, pin_direction_bit_i, pin_o, pin_oe_n_o, want;
  logic [1:0]  unit_irq_o, pwm_mode_o;
  logic [7:0]  exp_q[$];
  logic [3:0]  cm[4] = '{4'h4, 4'h5, 4'h6, 4'h7};
  int          np[4] = '{1, 1, 4, 16};
  logic [3:0]  mt[6] = '{4'h2, 4'h8, 4'h9, 4'hA, 4'hB, 4'h2};
  logic [5:0]  pre = 6'h04;
  logic [5:0]  post = 6'h23;
  int          failures, n_checks, n1, n3, na;

  dual_capture_compare_unit dut_u (.ref_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .first_timer_i, .third_timer_i, .first_timer_reset_o,
    .third_timer_reset_o, .adc_enabled_i, .adc_start_o, .pin_i, .port_latch_i,
    .pin_direction_bit_i, .pin_o, .pin_oe_n_o, .unit_irq_o, .pwm_mode_o, .pwm_timer_shared_o);
  pin_source src_u (.want_i(want), .pin_o(pin_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(input string w, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk_i) begin
    if (rd_d) cmp("rdata", 16'(exp_q.pop_front()), 16'(reg_rdata_o));
    rd_d <= reg_rd_i;
    n1 += 32'(first_timer_reset_o);
    n3 += 32'(third_timer_reset_o);
    na += 32'(adc_start_o);
  end

  // Timers count on the device clock
  always @(posedge ref_clk_i) begin
    if (first_timer_reset_o) first_timer_i <= 16'h0000;
    else if (run) first_timer_i <= first_timer_i + 16'h0001;
    if (third_timer_reset_o) third_timer_i <= 16'h0000;
    else if (run) third_timer_i <= third_timer_i + 16'h0001;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
  endtask

  task automatic pulse();
    want[0] <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    want[0] <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
  endtask

  task automatic cmp_run(input int u, input logic [3:0] m, input logic pb, input logic pa);
    int s1, s3, sa;
    first_timer_i <= 16'h0000;
    third_timer_i <= 16'h0000;
    wr(4'(2 + 3 * u), 8'h00);
    wr(4'(2 + 3 * u), {4'h0, m});
    wr(ADDR_FLAGS, 8'h00);
    cmp("pin start", 16'(pb), 16'(pin_o[u]));
    cmp("oe", 16'h0000, 16'(pin_oe_n_o[u]));
    s1 = n1;
    s3 = n3;
    sa = na;
    run <= 1'b1;
    repeat (int'(v) + 4) @(posedge ref_clk_i);
    run <= 1'b0;
    cmp("pin match", 16'(pa), 16'(pin_o[u]));
    rd(ADDR_FLAGS, 8'(2 << u));
    cmp("irq", 16'h0001, 16'(unit_irq_o[u]));
    cmp("first reset", 16'(u == 0 && m == MODE_CMP_TRIG), 16'(n1 - s1));
    cmp("third reset", 16'(u == 1 && m == MODE_CMP_TRIG), 16'(n3 - s3));
    cmp("adc", 16'(u == 1 && m == MODE_CMP_TRIG && adc_enabled_i), 16'(na - sa));
  endtask

  initial begin
    {reg_wr_i, reg_rd_i, run, rd_d, want, port_latch_i} = '0;
    {reg_addr_i, reg_wdata_i, first_timer_i, third_timer_i} = '0;
    {failures, n_checks, n1, n3, na} = '0;
    pin_direction_bit_i = 2'b01;
    adc_enabled_i = 1'b1;
    rstn_i = 1'b0;
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    void'($urandom(32'h357D));
    rd(ADDR_T3_CONTROL, T3_CONTROL_RST);
    rd(ADDR_FLAGS, 8'h00);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    wr(OFS_CONTROL, 8'hFF);
    wr(4'h5, 8'h0C);
    rd(OFS_CONTROL, 8'h3F);
    cmp("pwm mode", 16'h0003, 16'(pwm_mode_o));
    cmp("pwm shared", 16'h0001, 16'(pwm_timer_shared_o));
    wr(ADDR_ENABLES, 8'h06);
    rd(ADDR_ENABLES, 8'h06);
    foreach (cm[k]) begin
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_CONTROL, {4'h0, cm[k]});
      for (int r = 0; r < 2; r++) begin
        t = 16'($urandom);
        first_timer_i <= t;
        wr(ADDR_FLAGS, 8'h00);
        repeat (np[k] - 1) pulse();
        rd(ADDR_FLAGS, 8'h00);
        pulse();
        rd(ADDR_FLAGS, 8'h02);
        cmp("irq", 16'h0001, 16'(unit_irq_o[0]));
      end
      rd(OFS_VALUE_LOW, t[7:0]);
      rd(OFS_VALUE_HIGH, t[15:8]);
    end
    cmp("oe", 16'h0001, 16'(pin_oe_n_o[0]));
    wr(OFS_CONTROL, 8'h06);
    pulse();
    pulse();
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_CONTROL, 8'h06);
    wr(ADDR_FLAGS, 8'h00);
    repeat (3) pulse();
    rd(ADDR_FLAGS, 8'h00);
    wr(ADDR_T3_CONTROL, 8'h08);
    wr(4'h5, 8'h05);
    wr(ADDR_FLAGS, 8'h00);
    t = 16'($urandom);
    third_timer_i <= t;
    port_latch_i[1] <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rd(ADDR_FLAGS, 8'h04);
    rd(4'h3, t[7:0]);
    rd(4'h4, t[15:8]);
    port_latch_i[1] <= 1'b0;
    v = 8'(16 + $urandom_range(15));
    wr(OFS_VALUE_LOW, v);
    wr(OFS_VALUE_HIGH, 8'h00);
    wr(4'h3, v);
    wr(4'h4, 8'h00);
    // Compare drives the pin, so the first unit's pin turns to output
    pin_direction_bit_i[0] <= 1'b0;
    foreach (mt[i]) cmp_run(0, mt[i], pre[i], post[i]);
    wr(OFS_CONTROL, 8'h00);
    // Flag of the first unit still set; masking it must drop the request
    wr(ADDR_ENABLES, 8'h04);
    rd(ADDR_ENABLES, 8'h04);
    cmp("masked irq", 16'h0000, 16'(unit_irq_o[0]));
    cmp_run(1, MODE_CMP_TRIG, 1'b0, 1'b0);
    adc_enabled_i <= 1'b0;
    cmp_run(1, MODE_CMP_TRIG, 1'b0, 1'b0);
    repeat (4) @(posedge ref_clk_i);
    test_done();
  end

  initial begin
    repeat (60000) @(posedge ref_clk_i);
    failures++;
    test_done();
  end
endmodule // tb

bind dual_capture_compare_unit ccp_assertions chk_u (.ref_clk_i, .rstn_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .pin_o, .adc_enabled_i, .adc_start_o, .first_timer_reset_o,
  .third_timer_reset_o, .unit_irq_o, .pwm_mode_o, .pwm_timer_shared_o);
